// *** hdl/spc_pkg.sv ***
// Functional notes
// - Enable sequence 3D 2A 7F A9 sets protection
// - Disable sequence 3D 2A 7F 9A clears protection
// - Enabled protection refuses protected sector operations
// - Software protection starts cleared after power-up
// - Undriven protect pin reads as deasserted
// - Low pin blocks marked sectors and register
// - Pin assertion reports protection within assert delay
// - Pin release drops hardware-only protection
// - Software enable survives pin release
// - Disable ignored while protect pin asserted
// - Pin only forces protection, never releases
// - Protect pin filtered against short pulses
// - Status bit shows protection from either method
// - High pin leaves register readable and writable
// - Sixteen sector bytes, FFh protected, 00h not
package spc_pkg;

	// ----------------------------------------
	// Command sequence
	// ----------------------------------------
	localparam logic [7:0] SPC_CMD_BYTE0 = 8'h3D;
	localparam logic [7:0] SPC_CMD_BYTE1 = 8'h2A;
	localparam logic [7:0] SPC_CMD_BYTE2 = 8'h7F;
	localparam logic [7:0] SPC_CMD_ENABLE = 8'hA9;
	localparam logic [7:0] SPC_CMD_DISABLE = 8'h9A;
	localparam int SPC_CMD_BITS = 32;

	// ----------------------------------------
	// Protection register layout
	// ----------------------------------------
	localparam int SPC_SECTORS = 16;
	localparam int SPC_SECTOR_W = 4;
	localparam logic [7:0] SPC_SECT_PROTECTED = 8'hFF;
	localparam logic [7:0] SPC_SECT_RESET = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SPC_CLK_PERIOD_NS = 10;
	localparam int SPC_PROTECT_ASSERT_DELAY_NS = 1000;
	localparam int SPC_PROTECT_RELEASE_DELAY_NS = 1000;
	// Pin to status takes three cycles beyond the filter count
	localparam int SPC_ASSERT_CYCLES =
		SPC_PROTECT_ASSERT_DELAY_NS / SPC_CLK_PERIOD_NS - 4;
	localparam int SPC_RELEASE_CYCLES =
		SPC_PROTECT_RELEASE_DELAY_NS / SPC_CLK_PERIOD_NS - 4;

	// ----------------------------------------
	// Operation checker states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SPC_OP_IDLE = 2'b00,
		SPC_OP_CHECK = 2'b01,
		SPC_OP_ANSWER = 2'b10
	} spc_op_state_t;

endpackage : spc_pkg

// *** hdl/spc_sector_protect.sv ***
module spc_sector_protect
	import spc_pkg::*;
#(
	parameter int SECTORS = SPC_SECTORS,
	parameter int ASSERT_CYCLES = SPC_ASSERT_CYCLES,
	parameter int RELEASE_CYCLES = SPC_RELEASE_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic wp_n,
	input wire logic op_req,
	input wire logic op_target_reg,
	input wire logic [$clog2(SECTORS)-1:0] op_sector,
	input wire logic sect_we,
	input wire logic [$clog2(SECTORS)-1:0] sect_wr_idx,
	input wire logic [7:0] sect_wr_data,
	input wire logic [$clog2(SECTORS)-1:0] sect_rd_idx,
	output logic [7:0] sect_rd_data,
	output logic op_grant,
	output logic op_refuse,
	output logic op_ready,
	output logic prot_enabled,
	output logic sw_prot_enabled,
	output logic wp_active,
	output logic sect_reg_locked
);

	localparam int IDX_W = $clog2(SECTORS);
	localparam int BITCNT_W = 6;

	generate
		if (SECTORS < 2 || SECTORS > 256) begin : g_bad_sectors
			$error("spc_sector_protect: sector count out of range");
		end
		// Index ports carry no spare codes, so the count must fill them
		if ((SECTORS & (SECTORS - 1)) != 0) begin : g_bad_pow2
			$error("spc_sector_protect: sector count must be a power of two");
		end
		if (ASSERT_CYCLES < 1 || RELEASE_CYCLES < 1) begin : g_bad_filter
			$error("spc_sector_protect: filter lengths must be at least one cycle");
		end
		// Saturated count must sit above a full frame to reject long ones
		if (SPC_CMD_BITS >= (1 << BITCNT_W) - 1) begin : g_bad_bitcnt
			$error("spc_sector_protect: bit counter too narrow for the frame");
		end
	endgenerate

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic sck_s1_reg;
	logic sck_s2_reg;
	logic sck_d_reg;
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_d_reg;
	logic si_s1_reg;
	logic si_s2_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			sck_s1_reg <= 1'b0;
			sck_s2_reg <= 1'b0;
			sck_d_reg <= 1'b0;
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_d_reg <= 1'b1;
			si_s1_reg <= 1'b0;
			si_s2_reg <= 1'b0;
		end else begin
			sck_s1_reg <= spi_sck;
			sck_s2_reg <= sck_s1_reg;
			sck_d_reg <= sck_s2_reg;
			cs_s1_reg <= spi_cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_d_reg <= cs_s2_reg;
			si_s1_reg <= spi_si;
			si_s2_reg <= si_s1_reg;
		end
	end

	logic sck_rise;
	logic cs_fall;
	logic cs_rise;

	// Mode 0 and mode 3 both sample on the rising edge
	assign sck_rise = sck_s2_reg && !sck_d_reg && !cs_s2_reg;
	assign cs_fall = !cs_s2_reg && cs_d_reg;
	assign cs_rise = cs_s2_reg && !cs_d_reg;

	// ----------------------------------------
	// Command shifter
	// ----------------------------------------
	logic [SPC_CMD_BITS-1:0] shift_reg;
	logic [BITCNT_W-1:0] bitcnt_reg;

	// Shifts freely; only the bit count decides whether a frame is valid
	always_ff @(posedge clock) begin
		if (rst) begin
			shift_reg <= '0;
		end else if (sck_rise) begin
			shift_reg <= {shift_reg[SPC_CMD_BITS-2:0], si_s2_reg};
		end
	end

	// Saturates so that a longer frame never matches
	always_ff @(posedge clock) begin
		if (rst || cs_fall) begin
			bitcnt_reg <= '0;
		end else if (sck_rise && bitcnt_reg != '1) begin
			bitcnt_reg <= bitcnt_reg + BITCNT_W'(1);
		end
	end

	logic prefix_ok;
	logic frame_exact;
	logic cmd_enable;
	logic cmd_disable;

	assign prefix_ok = shift_reg[31:24] == SPC_CMD_BYTE0
		&& shift_reg[23:16] == SPC_CMD_BYTE1
		&& shift_reg[15:8] == SPC_CMD_BYTE2;
	assign frame_exact = bitcnt_reg == BITCNT_W'(SPC_CMD_BITS);
	// Acts only on chip select release after exactly four bytes
	assign cmd_enable = cs_rise && frame_exact && prefix_ok
		&& shift_reg[7:0] == SPC_CMD_ENABLE;
	assign cmd_disable = cs_rise && frame_exact && prefix_ok
		&& shift_reg[7:0] == SPC_CMD_DISABLE;

	// ----------------------------------------
	// Protect pin
	// ----------------------------------------
	logic hw_prot;

	spc_wp_filter #(
		.ASSERT_CYCLES(ASSERT_CYCLES),
		.RELEASE_CYCLES(RELEASE_CYCLES)
	) u_wp_filter (
		.clock(clock),
		.rst(rst),
		.wp_n_pin(wp_n),
		.wp_asserted(hw_prot)
	);

	// ----------------------------------------
	// Protection state
	// ----------------------------------------
	logic sw_en_reg;

	// Reset models power-up: software protection off
	always_ff @(posedge clock) begin
		if (rst) begin
			sw_en_reg <= 1'b0;
		end else if (cmd_enable) begin
			sw_en_reg <= 1'b1; // Taken even with pin low
		end else if (cmd_disable && !hw_prot) begin
			sw_en_reg <= 1'b0;
		end
	end

	logic prot_now;

	// Pin only adds protection, software state is never touched by it
	assign prot_now = sw_en_reg || hw_prot;

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	logic prot_reg;
	logic sw_reg;
	logic wp_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			prot_reg <= 1'b0;
			sw_reg <= 1'b0;
			wp_reg <= 1'b0;
		end else begin
			prot_reg <= prot_now;
			sw_reg <= sw_en_reg;
			wp_reg <= hw_prot;
		end
	end

	// ----------------------------------------
	// Sector protection bytes
	// ----------------------------------------
	logic [7:0] sect_mem [SECTORS];
	logic [SECTORS-1:0] sect_marked;

	// Register writes refused while the pin is asserted
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < SECTORS; i++) begin
				sect_mem[i] <= SPC_SECT_RESET;
			end
		end else if (sect_we && !hw_prot) begin
			sect_mem[sect_wr_idx] <= sect_wr_data;
		end
	end

	genvar g;
	generate
		for (g = 0; g < SECTORS; g++) begin : g_marked
			assign sect_marked[g] = sect_mem[g] == SPC_SECT_PROTECTED;
		end
	endgenerate

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [7:0] rd_reg;
	logic lock_reg;

	// Readable whatever the pin or software state
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_reg <= SPC_SECT_RESET;
			lock_reg <= 1'b0;
		end else begin
			rd_reg <= sect_mem[sect_rd_idx];
			lock_reg <= hw_prot;
		end
	end

	// ----------------------------------------
	// Program and erase gate
	// ----------------------------------------
	spc_op_state_t op_state_reg;
	logic op_target_hold_reg;
	logic [IDX_W-1:0] op_sector_hold_reg;
	logic op_block_reg;
	logic grant_reg;
	logic refuse_reg;
	logic ready_reg;

	logic block_now;

	// Register itself is blocked only by the pin
	assign block_now = op_target_hold_reg ? hw_prot
		: (prot_now && sect_marked[op_sector_hold_reg]);

	// Target is latched at the request so later input changes cannot steer it
	always_ff @(posedge clock) begin
		if (rst) begin
			op_state_reg <= SPC_OP_IDLE;
			op_target_hold_reg <= 1'b0;
			op_sector_hold_reg <= '0;
			op_block_reg <= 1'b0;
		end else begin
			case (op_state_reg)
				SPC_OP_IDLE: begin
					if (op_req) begin
						op_target_hold_reg <= op_target_reg;
						op_sector_hold_reg <= op_sector;
						op_state_reg <= SPC_OP_CHECK;
					end
				end
				SPC_OP_CHECK: begin
					op_block_reg <= block_now;
					op_state_reg <= SPC_OP_ANSWER;
				end
				SPC_OP_ANSWER: begin
					op_state_reg <= SPC_OP_IDLE;
				end
				default: begin
					op_state_reg <= SPC_OP_IDLE;
				end
			endcase
		end
	end

	// A refusal never starts a cycle; op_ready returns the cycle after op_refuse, as after a grant
	always_ff @(posedge clock) begin
		if (rst) begin
			grant_reg <= 1'b0;
			refuse_reg <= 1'b0;
			ready_reg <= 1'b1;
		end else begin
			grant_reg <= op_state_reg == SPC_OP_ANSWER && !op_block_reg;
			refuse_reg <= op_state_reg == SPC_OP_ANSWER && op_block_reg;
			ready_reg <= op_state_reg == SPC_OP_IDLE && !op_req;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sect_rd_data = rd_reg;
	assign op_grant = grant_reg;
	assign op_refuse = refuse_reg;
	assign op_ready = ready_reg;
	assign prot_enabled = prot_reg;
	assign sw_prot_enabled = sw_reg;
	assign wp_active = wp_reg;
	assign sect_reg_locked = lock_reg;

endmodule : spc_sector_protect

// *** hdl/spc_wp_filter.sv ***
module spc_wp_filter
	import spc_pkg::*;
#(
	parameter int ASSERT_CYCLES = SPC_ASSERT_CYCLES,
	parameter int RELEASE_CYCLES = SPC_RELEASE_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic wp_n_pin,
	output logic wp_asserted
);

	localparam int CNT_W = $clog2(ASSERT_CYCLES + RELEASE_CYCLES + 2);

	generate
		if (ASSERT_CYCLES < 1 || RELEASE_CYCLES < 1) begin : g_bad
			$error("spc_wp_filter: filter lengths must be at least one cycle");
		end
	endgenerate

	logic sync1_reg;
	logic sync2_reg;
	logic [CNT_W-1:0] stable_reg;
	logic asserted_reg;
	logic differs;
	logic [CNT_W-1:0] limit;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= wp_n_pin;
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------
	// Noise filter
	// ----------------------------------------
	assign differs = (~sync2_reg) != asserted_reg;
	assign limit = asserted_reg ? CNT_W'(RELEASE_CYCLES) : CNT_W'(ASSERT_CYCLES);

	// Level must differ for the full count before it is taken
	always_ff @(posedge clock) begin
		if (rst) begin
			stable_reg <= '0;
			asserted_reg <= 1'b0; // Pulled-up pin starts deasserted
		end else if (!differs) begin
			stable_reg <= '0;
		end else if (stable_reg + CNT_W'(1) >= limit) begin
			stable_reg <= '0;
			asserted_reg <= ~asserted_reg;
		end else begin
			stable_reg <= stable_reg + CNT_W'(1);
		end
	end

	assign wp_asserted = asserted_reg;

endmodule : spc_wp_filter

// *** verification/spc_sector_protect_monitor.sv ***
module spc_sector_protect_monitor #(
	parameter int ASSERT_CYCLES = 96,
	parameter int RELEASE_CYCLES = 96
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic wp_n,
	input wire logic op_req,
	input wire logic op_target_reg,
	input wire logic op_grant,
	input wire logic op_refuse,
	input wire logic op_ready,
	input wire logic prot_enabled,
	input wire logic sw_prot_enabled,
	input wire logic wp_active,
	input wire logic sect_reg_locked
);
	default clocking mon_cb @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_op_answer: assert property (op_req && op_ready |-> ##3 (op_grant ^ op_refuse))
		else $error("operation answer missing");
	chk_op_busy: assert property (op_req && op_ready |=> !op_ready [*3])
		else $error("gate not busy");
	chk_refuse_ready: assert property (op_refuse && !op_req |=> op_ready)
		else $error("gate not ready after refusal");
	chk_status_or: assert property (prot_enabled == (sw_prot_enabled || wp_active))
		else $error("status bit wrong");
	chk_lock_pin: assert property (sect_reg_locked == wp_active)
		else $error("lock differs from pin");
	chk_reg_locked: assert property (
		op_req && op_ready && op_target_reg ##2 wp_active |-> ##1 op_refuse)
		else $error("register op not refused");
	chk_reg_free: assert property (
		op_req && op_ready && op_target_reg ##2 !wp_active |-> ##1 op_grant)
		else $error("register op not granted");
	chk_open_grant: assert property (
		op_req && op_ready && !op_target_reg ##2 !prot_enabled |-> ##1 op_grant)
		else $error("open op not granted");
	chk_disable_held: assert property (wp_active [*3] |-> !$fell(sw_prot_enabled))
		else $error("disable taken with pin low");
	chk_power_up: assert property ($fell(rst) |-> !sw_prot_enabled)
		else $error("protection on after reset");
	chk_pin_filter: assert property (
		$rose(wp_active) |-> !$past(wp_n, 4) && !$past(wp_n, ASSERT_CYCLES + 3))
		else $error("pin pulse passed filter");
	chk_pin_release: assert property (
		$fell(wp_active) |-> $past(wp_n, 4) && $past(wp_n, RELEASE_CYCLES + 3))
		else $error("pin release passed filter");
endmodule : spc_sector_protect_monitor

bind spc_sector_protect spc_sector_protect_monitor #(
	.ASSERT_CYCLES(ASSERT_CYCLES),
	.RELEASE_CYCLES(RELEASE_CYCLES)
) u_monitor (
	.clock(clock), .rst(rst), .wp_n(wp_n), .op_req(op_req), .op_target_reg(op_target_reg),
	.op_grant(op_grant), .op_refuse(op_refuse), .op_ready(op_ready),
	.prot_enabled(prot_enabled), .sw_prot_enabled(sw_prot_enabled),
	.wp_active(wp_active), .sect_reg_locked(sect_reg_locked)
);

// *** verification/spc_sector_protect_tb_top.sv ***
module spc_sector_protect_tb_top
	import spc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int FILT = 6;
	localparam logic [31:0] ENA = {SPC_CMD_BYTE0, SPC_CMD_BYTE1, SPC_CMD_BYTE2, SPC_CMD_ENABLE};
	localparam logic [31:0] DIS = {SPC_CMD_BYTE0, SPC_CMD_BYTE1, SPC_CMD_BYTE2, SPC_CMD_DISABLE};
	typedef struct packed {logic [3:0] sec; logic [7:0] val; logic tgt; logic [1:0] ans;} spc_row_t;
	logic clock, rst, start, wp_low, op_req, op_target_reg, sect_we, busy, spi_sck, spi_cs_n, spi_si;
	logic [31:0] frame;
	logic [5:0] nbits;
	logic [3:0] op_sector, sect_wr_idx, sect_rd_idx;
	logic [7:0] sect_wr_data, sect_rd_data;
	logic op_grant, op_refuse, op_ready, prot_enabled, sw_prot_enabled, wp_active, sect_reg_locked;
	logic [1:0] ans;
	int n_errors = 0;
	int samples_checked = 0;
	spc_row_t rows [6];
	// Pull-up stands in for the pin's own, so undriven reads high
	tri1 wp_line;
	assign wp_line = wp_low ? 1'h0 : 1'hz;

	spc_sector_protect #(.ASSERT_CYCLES(FILT), .RELEASE_CYCLES(FILT)) u_dut (
		.clock(clock), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.wp_n(wp_line), .op_req(op_req), .op_target_reg(op_target_reg), .op_sector(op_sector),
		.sect_we(sect_we), .sect_wr_idx(sect_wr_idx), .sect_wr_data(sect_wr_data),
		.sect_rd_idx(sect_rd_idx), .sect_rd_data(sect_rd_data),
		.op_grant(op_grant), .op_refuse(op_refuse), .op_ready(op_ready),
		.prot_enabled(prot_enabled), .sw_prot_enabled(sw_prot_enabled),
		.wp_active(wp_active), .sect_reg_locked(sect_reg_locked)
	);
	spc_spi_host u_host (
		.start(start), .frame(frame), .nbits(nbits), .busy(busy),
		.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si)
	);

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	initial begin
		#300us;
		n_errors++;
		complete_run();
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	task automatic send(input logic [31:0] f, input logic [5:0] n);
		frame = f;
		nbits = n;
		start = 1'h1;
		@(posedge clock);
		#1 start = 1'h0;
		for (int k = 0; k < 600 && busy; k++) @(posedge clock);
		check("host done", busy, 1'h0);
		// Answer lands 4 cycles after select rises
		repeat (8) @(posedge clock);
		#1;
	endtask : send
	task automatic do_op(input logic tgt, input logic [3:0] sec);
		op_target_reg = tgt;
		op_sector = sec;
		op_req = 1'h1;
		@(posedge clock);
		#1 op_req = 1'h0;
		repeat (2) @(posedge clock);
		#1 ans = {op_grant, op_refuse};
		@(posedge clock);
		#1 check("ready", op_ready, 1'h1);
	endtask : do_op
	task automatic wr(input logic [3:0] idx, input logic [7:0] val);
		sect_we = 1'h1;
		sect_wr_idx = idx;
		sect_wr_data = val;
		sect_rd_idx = idx;
		@(posedge clock);
		#1 sect_we = 1'h0;
		repeat (2) @(posedge clock);
		#1;
	endtask : wr
	task automatic set_wp(input logic low);
		int n;
		n = 0;
		wp_low = low;
		while (wp_active !== low && n < 50) begin
			@(posedge clock);
			#1 n++;
		end
		check("pin delay", n <= FILT + 6, 1'h1);
	endtask : set_wp

	initial begin
		rst = 1'h1;
		{start, frame, nbits, wp_low, op_req, op_target_reg, op_sector} = '0;
		{sect_we, sect_wr_idx, sect_wr_data, sect_rd_idx} = 0;
		rows = '{'{4'h3, 8'hFF, 1'h0, 2'h1}, '{4'h4, 8'h00, 1'h0, 2'h2}, '{4'hF, 8'hFF, 1'h0, 2'h1},
			'{4'h0, 8'h00, 1'h0, 2'h2}, '{4'h7, 8'h7E, 1'h0, 2'h2}, '{4'h9, 8'h00, 1'h1, 2'h2}};
		repeat (8) @(posedge clock);
		#1 rst = 1'h0;
		check("idle", {op_ready, sw_prot_enabled, prot_enabled, wp_active}, 8'h8);
		send(ENA, 32);
		check("enable", sw_prot_enabled, 1'h1);
		foreach (rows[i]) begin
			wr(rows[i].sec, rows[i].val);
			check("byte", sect_rd_data, rows[i].val);
			do_op(rows[i].tgt, rows[i].sec);
			check("answer", ans, rows[i].ans);
		end
		send(DIS, 32);
		check("disable", prot_enabled, 1'h0);
		do_op(1'h0, 4'h3);
		check("open op", ans, 2'h2);
		send(ENA, 31);
		check("short frame", sw_prot_enabled, 1'h0);
		wp_low = 1'h1;
		repeat (3) @(posedge clock);
		#1 wp_low = 1'h0;
		repeat (20) @(posedge clock);
		#1 check("glitch", wp_active, 1'h0);
		set_wp(1'h1);
		check("pin lock", {prot_enabled, sect_reg_locked, sw_prot_enabled}, 8'h6);
		wp_low = 1'h0;
		repeat (3) @(posedge clock);
		#1 wp_low = 1'h1;
		repeat (20) @(posedge clock);
		#1 check("release glitch", wp_active, 1'h1);
		do_op(1'h1, 4'h0);
		check("reg op", ans, 2'h1);
		do_op(1'h0, 4'h3);
		check("pin op", ans, 2'h1);
		wr(4'h3, 8'h00);
		check("locked byte", sect_rd_data, 8'hFF);
		set_wp(1'h0);
		check("release", prot_enabled, 1'h0);
		set_wp(1'h1);
		send(ENA, 32);
		send(DIS, 32);
		check("held", sw_prot_enabled, 1'h1);
		set_wp(1'h0);
		check("kept", prot_enabled, 1'h1);
		send(DIS, 32);
		check("dropped", prot_enabled, 1'h0);
		send(ENA, 32);
		check("re-enable", sw_prot_enabled, 1'h1);
		rst = 1'h1;
		repeat (2) @(posedge clock);
		#1 rst = 1'h0;
		@(posedge clock);
		#1 check("power-up", {sw_prot_enabled, prot_enabled, op_ready}, 8'h1);
		complete_run();
	end
endmodule : spc_sector_protect_tb_top

// *** verification/spc_spi_host.sv ***
module spc_spi_host (
	input wire logic start,
	input wire logic [31:0] frame,
	input wire logic [5:0] nbits,
	output logic busy,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		busy = 1'h0;
		spi_sck = 1'h0;
		spi_cs_n = 1'h1;
		spi_si = 1'h1;
	end
	// Clock stands low between frames, mode 0
	always @(posedge start) begin
		busy = 1'h1;
		spi_cs_n = 1'h0;
		for (int i = 0; i < nbits; i++) begin
			spi_si = frame[31 - i];
			#62.5 spi_sck = 1'h1;
			#62.5 spi_sck = 1'h0;
		end
		#62.5 spi_cs_n = 1'h1;
		// Released line must not keep the last bit
		spi_si = ~spi_si;
		#62.5 busy = 1'h0;
	end
endmodule : spc_spi_host
